// file: design/rps_regs.svh
// Purpose: offsets, fields, reset values and timing counts of the playback sequencer
// Assumes: AXI4-Lite byte addresses, one aligned 32-bit word per register
// Notes: a write to the commit word copies the staged registers into the active set
//
// Summary of operation
// - continuous modes are refused while the scaling multipliers are the destination.
// - ramp-up starts on commit or any trigger change, loading the segment start.
// - ramp-up counts upward from start and halts at the end address.
// - each step-timer expiry moves the address by exactly one location, except the recirculate wrap from end to start.
// - step period is the baseband sample tick or the programmed step rate.
// - bidirectional commit only arms with segment zero; the trigger starts it.
// - bidirectional rising trigger loads segment zero start, counts up, halts at end.
// - bidirectional falling trigger loads segment one end, counts down, halts at start.
// - in bidirectional mode a trigger change mid-ramp restarts the timer and reloads the new segment's start or end address at once.
// - continuous bidirectional counts up from start, reversing at each terminal address.
// - in continuous modes a trigger change aborts and restarts from the new segment.
// - continuous bidirectional runs until the next commit or trigger change.
// - recirculate loads start on the expiry after the end address, repeating.
// - rising trigger selects segment zero, falling trigger selects segment one.
// - mode codes 1 ramp-up, 2 bidirectional, 3 continuous bidirectional, 4 recirculate.
`ifndef RPS_REGS_SVH
`define RPS_REGS_SVH
`define RPS_SEG0_BND_OFS 8'h00
`define RPS_SEG0_CFG_OFS 8'h04
`define RPS_SEG1_BND_OFS 8'h08
`define RPS_SEG1_CFG_OFS 8'h0C
`define RPS_CTRL_OFS 8'h10
`define RPS_COMMIT_OFS 8'h14
`define RPS_STATUS_OFS 8'h18
`define RPS_START_LSB 0
`define RPS_END_LSB 16
`define RPS_STEP_LSB 0
`define RPS_MODE_LSB 16
`define RPS_CTRL_EN_BIT 0
`define RPS_CTRL_DEST_BIT 1
`define RPS_BND_MASK 32'h03FF03FF
`define RPS_CFG_MASK 32'h0007FFFF
`define RPS_CTRL_MASK 32'h00000003
`define RPS_BND_RST 32'h00000000
`define RPS_CFG_RST 32'h00010001
`define RPS_CTRL_RST 32'h00000000
`define RPS_CLK_MHZ 25
`define RPS_STEP_UNIT_NS 160
`define RPS_STEP_UNIT_CYC ((`RPS_STEP_UNIT_NS * `RPS_CLK_MHZ + 999) / 1000)
`define RPS_RESP_OKAY 2'h0
`define RPS_RESP_SLVERR 2'h2
`endif

// file: design/rps_pkg.sv
// Purpose: types of the playback sequencer
// Assumes: one-hot state codes
// Notes: mode codes match the three-bit playback mode field
package rps_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_ARMED = 4'h2,
    ST_RUN = 4'h4,
    ST_HALT = 4'h8
  } rps_state_type;
  typedef enum logic [2:0] {
    MODE_RAMP = 3'h1,
    MODE_BIDIR = 3'h2,
    MODE_CBIDIR = 3'h3,
    MODE_RECIRC = 3'h4
  } rps_mode_type;
endpackage

// file: design/rps_sequencer.sv
// Purpose: waveform RAM address sequencer with AXI4-Lite registers
// Assumes: all inputs synchronous to aclk; bb_sample_tick pulses once per baseband sample
// Notes: addresses leave through a two-entry buffer; a full buffer stalls the step timer
`timescale 1ns/1ps
`include "rps_regs.svh"
module rps_sequencer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  input wire logic playback_trigger_pin,
  input wire logic bb_sample_tick,
  output logic [9:0] ram_addr,
  output logic ram_addr_valid,
  input wire logic ram_addr_ready,
  output logic mult_zero,
  output rps_pkg::rps_state_type seq_state
);
  import rps_pkg::*;

  logic [31:0] regs_r [0:4];
  logic [31:0] act_r [0:4];
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic aw_got_r, w_got_r, do_wr, wr_ok;
  logic [2:0] widx, ridx;
  logic commit_d_r;
  logic pin_prev_r, pin_ok_r;
  logic rise, fall, tedge, evt, ev_ok, en, dest;
  logic ev_seg;
  logic [2:0] ev_mode;
  rps_state_type state_r;
  logic [2:0] mode_r;
  logic seg_r, dir_r;
  logic [9:0] addr_r, addr_nxt, cur_start, cur_end, nxt_up, nxt_dn;
  logic push_pend_r, expire, halt_nxt, dir_nxt;
  logic [19:0] tmr_r, period;
  logic [15:0] stp;
  logic [9:0] hold_r;
  logic hold_valid_r, buf_in_ready;
  logic [31:0] status;

  // ---------------- AXI4-Lite write path ----------------
  assign do_wr = aw_got_r && w_got_r && !s_bvalid;
  assign widx = awaddr_r[4:2];
  assign wr_ok = (awaddr_r[7:5] == 3'h0) && (widx != 3'h7);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_awready <= 1'b1;
      s_wready <= 1'b1;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      s_bvalid <= 1'b0;
      s_bresp <= `RPS_RESP_OKAY;
    end else begin
      if (s_awvalid && s_awready) begin
        awaddr_r <= s_awaddr;
        aw_got_r <= 1'b1;
        s_awready <= 1'b0;
      end
      if (s_wvalid && s_wready) begin
        wdata_r <= s_wdata;
        wstrb_r <= s_wstrb;
        w_got_r <= 1'b1;
        s_wready <= 1'b0;
      end
      if (do_wr) begin
        s_bvalid <= 1'b1;
        s_bresp <= wr_ok ? `RPS_RESP_OKAY : `RPS_RESP_SLVERR;
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
      end
      if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
        s_awready <= 1'b1;
        s_wready <= 1'b1;
      end
    end
  end

  // staged registers, byte-lane writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      regs_r[0] <= `RPS_BND_RST;
      regs_r[1] <= `RPS_CFG_RST;
      regs_r[2] <= `RPS_BND_RST;
      regs_r[3] <= `RPS_CFG_RST;
      regs_r[4] <= `RPS_CTRL_RST;
    end else if (do_wr && wr_ok && widx < 3'h5) begin
      for (int b = 0; b < 4; b++) begin
        if (wstrb_r[b]) begin
          regs_r[widx][8*b +: 8] <= wdata_r[8*b +: 8];
        end
      end
    end
  end

  // commit word copies the staged set into the active set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      act_r[0] <= `RPS_BND_RST;
      act_r[1] <= `RPS_CFG_RST;
      act_r[2] <= `RPS_BND_RST;
      act_r[3] <= `RPS_CFG_RST;
      act_r[4] <= `RPS_CTRL_RST;
      commit_d_r <= 1'b0;
    end else begin
      commit_d_r <= do_wr && (awaddr_r == `RPS_COMMIT_OFS);
      if (do_wr && (awaddr_r == `RPS_COMMIT_OFS)) begin
        for (int i = 0; i < 5; i++) begin
          act_r[i] <= regs_r[i];
        end
      end
    end
  end

  // ---------------- AXI4-Lite read path ----------------
  assign ridx = s_araddr[4:2];
  assign status = {10'h000, mult_zero, state_r == ST_ARMED, state_r == ST_HALT, seg_r,
                   dir_r, state_r == ST_RUN, 6'h00, addr_r};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_arready <= 1'b1;
      s_rvalid <= 1'b0;
      s_rdata <= 32'h00000000;
      s_rresp <= `RPS_RESP_OKAY;
    end else if (s_arvalid && s_arready) begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b1;
      s_rresp <= `RPS_RESP_OKAY;
      s_rdata <= 32'h00000000;
      if (s_araddr[7:5] != 3'h0 || ridx == 3'h7) begin
        s_rresp <= `RPS_RESP_SLVERR;
      end else begin
        case (ridx)
          3'h0, 3'h2: s_rdata <= regs_r[ridx] & `RPS_BND_MASK;
          3'h1, 3'h3: s_rdata <= regs_r[ridx] & `RPS_CFG_MASK;
          3'h4: s_rdata <= regs_r[4] & `RPS_CTRL_MASK;
          3'h6: s_rdata <= status;
          default: s_rdata <= 32'h00000000;
        endcase
      end
    end else if (s_rvalid && s_rready) begin
      s_rvalid <= 1'b0;
      s_arready <= 1'b1;
    end
  end

  // ---------------- trigger edges ----------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_prev_r <= 1'b0;
      pin_ok_r <= 1'b0;
    end else begin
      pin_prev_r <= playback_trigger_pin;
      pin_ok_r <= 1'b1;
    end
  end

  assign rise = pin_ok_r && playback_trigger_pin && !pin_prev_r;
  assign fall = pin_ok_r && !playback_trigger_pin && pin_prev_r;
  assign tedge = rise || fall;
  assign en = act_r[4][`RPS_CTRL_EN_BIT];
  assign dest = act_r[4][`RPS_CTRL_DEST_BIT];

  // ---------------- event decode ----------------
  always_comb begin
    ev_seg = seg_r;
    if (tedge) begin
      ev_seg = fall;
    end else if (act_r[{seg_r, 1'b1}][`RPS_MODE_LSB +: 3] == MODE_BIDIR) begin
      ev_seg = 1'b0;
    end
    ev_mode = act_r[{ev_seg, 1'b1}][`RPS_MODE_LSB +: 3];
    ev_ok = (ev_mode >= MODE_RAMP) && (ev_mode <= MODE_RECIRC);
    if (dest && (ev_mode == MODE_CBIDIR || ev_mode == MODE_RECIRC)) begin
      ev_ok = 1'b0;
    end
  end

  assign evt = en && (commit_d_r || tedge);
  assign cur_start = act_r[{seg_r, 1'b0}][`RPS_START_LSB +: 10];
  assign cur_end = act_r[{seg_r, 1'b0}][`RPS_END_LSB +: 10];
  // a restart takes the step rate of the segment being entered, not the one left
  assign stp = act_r[{(evt ? ev_seg : seg_r), 1'b1}][`RPS_STEP_LSB +: 16];

  // ---------------- step timer ----------------
  assign period = 20'(((stp == 16'h0000) ? 16'h0001 : stp) * `RPS_STEP_UNIT_CYC) - 20'h00001;
  assign expire = (state_r == ST_RUN) && !push_pend_r &&
                  (dest ? (tmr_r == 20'h00000) : bb_sample_tick);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tmr_r <= 20'h00000;
    end else if (evt || expire) begin
      tmr_r <= period;
    end else if (state_r == ST_RUN && tmr_r != 20'h00000) begin
      tmr_r <= tmr_r - 20'h00001;
    end
  end

  // ---------------- address step ----------------
  assign nxt_up = addr_r + 10'h001;
  assign nxt_dn = addr_r - 10'h001;

  always_comb begin
    addr_nxt = dir_r ? nxt_up : nxt_dn;
    dir_nxt = dir_r;
    halt_nxt = 1'b0;
    case (mode_r)
      MODE_RAMP, MODE_BIDIR: begin
        halt_nxt = dir_r ? (nxt_up == cur_end) : (nxt_dn == cur_start);
      end
      MODE_CBIDIR: begin
        if (dir_r ? (addr_r == cur_end) : (addr_r == cur_start)) begin
          dir_nxt = !dir_r;
          addr_nxt = dir_r ? nxt_dn : nxt_up;
        end
      end
      MODE_RECIRC: begin
        addr_nxt = (addr_r == cur_end) ? cur_start : nxt_up;
      end
      default: begin
        halt_nxt = 1'b1;
      end
    endcase
  end

  // ---------------- playback state machine ----------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= ST_IDLE;
      mode_r <= MODE_RAMP;
      seg_r <= 1'b0;
      dir_r <= 1'b1;
      addr_r <= 10'h000;
      push_pend_r <= 1'b0;
    end else if (!en) begin
      state_r <= ST_IDLE;
      push_pend_r <= 1'b0;
    end else if (evt) begin
      seg_r <= ev_seg;
      mode_r <= ev_mode;
      if (!tedge && ev_mode == MODE_BIDIR) begin
        state_r <= ST_ARMED;
      end else if (ev_ok) begin
        state_r <= ST_RUN;
        push_pend_r <= 1'b1;
        if (ev_mode == MODE_BIDIR && fall) begin
          addr_r <= act_r[2][`RPS_END_LSB +: 10];
          dir_r <= 1'b0;
        end else begin
          addr_r <= act_r[{ev_seg, 1'b0}][`RPS_START_LSB +: 10];
          dir_r <= 1'b1;
        end
      end else begin
        state_r <= ST_IDLE;
      end
    end else if (expire) begin
      addr_r <= addr_nxt;
      dir_r <= dir_nxt;
      push_pend_r <= 1'b1;
      if (halt_nxt) begin
        state_r <= ST_HALT;
      end
    end else if (push_pend_r && buf_in_ready) begin
      push_pend_r <= 1'b0;
    end
  end

  // multipliers see zero from a commit until the next trigger change
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mult_zero <= 1'b0;
    end else if (en && dest && tedge) begin
      mult_zero <= 1'b0;
    end else if (en && dest && commit_d_r) begin
      mult_zero <= 1'b1;
    end
  end

  // ---------------- two-entry output buffer ----------------
  assign buf_in_ready = !hold_valid_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ram_addr <= 10'h000;
      ram_addr_valid <= 1'b0;
      hold_r <= 10'h000;
      hold_valid_r <= 1'b0;
    end else if (ram_addr_valid && !ram_addr_ready) begin
      if (push_pend_r && buf_in_ready) begin
        hold_r <= addr_r;
        hold_valid_r <= 1'b1;
      end
    end else if (hold_valid_r) begin
      ram_addr <= hold_r;
      ram_addr_valid <= 1'b1;
      hold_valid_r <= 1'b0;
    end else begin
      ram_addr <= addr_r;
      ram_addr_valid <= push_pend_r;
    end
  end

  assign seq_state = state_r;

  // ---------------- assertions ----------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_trig_load;
    en && tedge && ev_ok;
  endsequence

  step_by_one_a: assert property (expire && !evt && en && mode_r != MODE_RECIRC
    |=> (addr_r == $past(addr_r) + 10'h001) || (addr_r == $past(addr_r) - 10'h001))
    else $error("address step not one");
  ramp_halts_end_a: assert property (expire && !evt && en && mode_r == MODE_RAMP
    && nxt_up == cur_end |=> state_r == ST_HALT && addr_r == $past(cur_end))
    else $error("ramp did not halt at end");
  no_cont_mult_a: assert property (state_r == ST_RUN && dest
    |-> mode_r == MODE_RAMP || mode_r == MODE_BIDIR)
    else $error("continuous mode with multiplier destination");
  bidir_arm_only_a: assert property (en && commit_d_r && !tedge && ev_mode == MODE_BIDIR
    |=> state_r == ST_ARMED && $stable(addr_r) && !seg_r)
    else $error("bidirectional commit did not arm");
  rise_seg_zero_a: assert property (s_trig_load and rise
    |=> !seg_r && state_r == ST_RUN)
    else $error("rising trigger did not select segment zero");
  fall_load_end_a: assert property (s_trig_load and (fall && ev_mode == MODE_BIDIR)
    |=> seg_r && !dir_r && addr_r == act_r[2][25:16])
    else $error("falling trigger did not load segment one end");
  timer_restart_a: assert property (s_trig_load and dest
    |=> tmr_r == $past(period))
    else $error("timer not restarted on trigger");
  halt_holds_a: assert property (state_r == ST_HALT && en && !evt
    |=> $stable(addr_r) [*1] ##1 (state_r != ST_HALT || !en || $stable(addr_r)))
    else $error("halted address moved");
  recirc_wrap_a: assert property (expire && !evt && en && mode_r == MODE_RECIRC
    && addr_r == cur_end |=> addr_r == $past(cur_start) && state_r == ST_RUN)
    else $error("recirculate did not wrap to start");
  cbidir_turn_a: assert property (expire && !evt && en && mode_r == MODE_CBIDIR
    && dir_r && addr_r == cur_end |=> !dir_r && state_r == ST_RUN)
    else $error("continuous ramp did not reverse at end");
endmodule

// file: bench/rps_addr_sink.sv
// Purpose: far-side model that accepts RAM addresses from the sequencer
// Assumes: the bench raises stall to hold the consumer off
// Notes: ready only drops on request; a stalled word must wait, never vanish
`timescale 1ns/1ps
module rps_addr_sink (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic stall,
  output logic ram_addr_ready
);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ram_addr_ready <= 1'b0;
    end else begin
      ram_addr_ready <= !stall;
    end
  end
endmodule

// file: bench/tb_top.sv
// Purpose: register-driven tests of the playback sequencer
// Assumes: AXI4-Lite master tasks, sample tick every second cycle
// Notes: accepted addresses are logged with their times and compared
`timescale 1ns/1ps
`include "rps_regs.svh"
module tb_top;
  import rps_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, pin, tick, stall, av, ar, mult_zero;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp, r;
  logic [9:0] ram_addr;
  logic [2:0] bad [4];
  rps_state_type seq_state;
  int fails, n_checks, cyc, k;
  logic [9:0] got [$];
  time ts [$];
  rps_sequencer u_rps_sequencer (.aclk(aclk), .aresetn(aresetn), .s_awaddr(awaddr),
    .s_awvalid(awvalid), .s_awready(awready), .s_wdata(wdata), .s_wstrb(4'hF),
    .s_wvalid(wvalid), .s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid),
    .s_bready(bready), .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready),
    .s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready),
    .playback_trigger_pin(pin), .bb_sample_tick(tick), .ram_addr(ram_addr),
    .ram_addr_valid(av), .ram_addr_ready(ar), .mult_zero(mult_zero), .seq_state(seq_state));
  rps_addr_sink u_rps_addr_sink (.aclk(aclk), .aresetn(aresetn), .stall(stall),
    .ram_addr_ready(ar));
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  always @(posedge aclk) tick <= aresetn ? !tick : 1'b0;
  always @(posedge aclk) begin
    if (aresetn && av && ar) begin
      got.push_back(ram_addr);
      ts.push_back($time);
    end
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      results();
    end
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    logic aw_d, w_d;
    aw_d = 1'b0;
    w_d = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_d && w_d)) begin
      @(posedge aclk);
      if (!aw_d && awready) begin
        aw_d = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_d && wready) begin
        w_d = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task seg(input logic [7:0] b, input logic [9:0] s, input logic [9:0] e,
    input logic [2:0] m, input logic [15:0] st);
    wr(b, {6'h00, e, 6'h00, s});
    wr(b + 8'h04, {13'h0000, m, st});
  endtask
  task go(input logic [31:0] c);
    wr(`RPS_CTRL_OFS, c);
    wr(`RPS_COMMIT_OFS, 32'h00000000);
  endtask
  task stop;
    go(32'h00000000);
    repeat (10) @(posedge aclk);
    got.delete();
    ts.delete();
  endtask
  task trig(input logic v);
    @(posedge aclk);
    pin <= v;
  endtask
  task exp_seq(input logic [9:0] e [$]);
    k = 0;
    while (got.size() < e.size() && k < 500) begin
      @(posedge aclk);
      k++;
    end
    foreach (e[i]) check({22'h000000, (i < got.size()) ? got[i] : 10'hXXX}, {22'h000000, e[i]});
  endtask
  task results;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, pin, stall} = 8'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h00000000;
    bad = '{3'h0, 3'h5, 3'h6, 3'h7};
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(`RPS_SEG0_CFG_OFS);
    check(d, `RPS_CFG_RST);
    rd(`RPS_CTRL_OFS);
    check(d, `RPS_CTRL_RST);
    rd(8'h1C);
    check({30'h00000000, r}, 32'h00000002);
    wr(8'h1C, 32'h00000000);
    check({30'h00000000, r}, 32'h00000002);
    wr(`RPS_SEG1_BND_OFS, 32'hFFFFFFFF);
    rd(`RPS_SEG1_BND_OFS);
    check(d, `RPS_BND_MASK);
    $display("test registers done");
    seg(`RPS_SEG0_BND_OFS, 10'h005, 10'h008, 3'h1, 16'h0001);
    stall <= 1'b1;
    go(32'h00000001);
    repeat (20) @(posedge aclk);
    stall <= 1'b0;
    exp_seq('{10'h005, 10'h006, 10'h007, 10'h008});
    repeat (30) @(posedge aclk);
    check(32'(got.size()), 32'h00000004);
    check({28'h0000000, seq_state}, {28'h0000000, ST_HALT});
    got.delete();
    trig(1'b1);
    exp_seq('{10'h005, 10'h006, 10'h007, 10'h008});
    stop();
    $display("test ramp-up done");
    seg(`RPS_SEG0_BND_OFS, 10'h00A, 10'h00D, 3'h2, 16'h0001);
    seg(`RPS_SEG1_BND_OFS, 10'h014, 10'h017, 3'h2, 16'h0001);
    go(32'h00000001);
    repeat (30) @(posedge aclk);
    check(32'(got.size()), 32'h00000000);
    check({28'h0000000, seq_state}, {28'h0000000, ST_ARMED});
    trig(1'b0);
    exp_seq('{10'h017, 10'h016, 10'h015, 10'h014});
    repeat (20) @(posedge aclk);
    check(32'(got.size()), 32'h00000004);
    got.delete();
    trig(1'b1);
    exp_seq('{10'h00A, 10'h00B, 10'h00C, 10'h00D});
    got.delete();
    trig(1'b0);
    repeat (5) @(posedge aclk);
    trig(1'b1);
    repeat (40) @(posedge aclk);
    check({22'h000000, got[0]}, 32'h00000017);
    for (int i = 0; i < 4; i++) check({22'h000000, got[got.size() - 4 + i]}, 32'hA + i);
    stop();
    $display("test bidirectional done");
    seg(`RPS_SEG0_BND_OFS, 10'h000, 10'h002, 3'h3, 16'h0001);
    go(32'h00000001);
    exp_seq('{10'h000, 10'h001, 10'h002, 10'h001, 10'h000, 10'h001, 10'h002});
    stop();
    seg(`RPS_SEG0_BND_OFS, 10'h000, 10'h002, 3'h4, 16'h0001);
    seg(`RPS_SEG1_BND_OFS, 10'h064, 10'h067, 3'h4, 16'h0001);
    go(32'h00000001);
    exp_seq('{10'h000, 10'h001, 10'h002, 10'h000, 10'h001, 10'h002});
    trig(1'b0);
    repeat (40) @(posedge aclk);
    k = 0;
    while (k < got.size() - 2 && got[k] < 10'h064) k++;
    check({22'h000000, got[k]}, 32'h00000064);
    check({22'h000000, got[k + 1]}, 32'h00000065);
    stop();
    $display("test continuous done");
    seg(`RPS_SEG0_BND_OFS, 10'h000, 10'h003, 3'h1, 16'h0002);
    go(32'h00000003);
    repeat (3) @(posedge aclk);
    check({31'h00000000, mult_zero}, 32'h00000001);
    trig(1'b1);
    exp_seq('{10'h000, 10'h001, 10'h002, 10'h003});
    check(32'(ts[2] - ts[1]), 32'd320);
    check({31'h00000000, mult_zero}, 32'h00000000);
    for (int m = 3; m < 5; m++) begin
      seg(`RPS_SEG0_BND_OFS, 10'h000, 10'h003, 3'(m), 16'h0001);
      go(32'h00000003);
      repeat (5) @(posedge aclk);
      check({28'h0000000, seq_state}, {28'h0000000, ST_IDLE});
    end
    foreach (bad[i]) begin
      seg(`RPS_SEG0_BND_OFS, 10'h000, 10'h003, bad[i], 16'h0001);
      go(32'h00000001);
      repeat (5) @(posedge aclk);
      check({28'h0000000, seq_state}, {28'h0000000, ST_IDLE});
    end
    $display("test destination and modes done");
    results();
  end
endmodule
